// ---- cap_space_defines.svh ----
// Purpose: Offsets, field positions and fixed values of the capability register bank.
// Assumes: 24-bit configuration byte offsets, 32-bit register words.
// Notes: Included by the bank only; definitions only.
`ifndef CAP_SPACE_DEFINES_SVH
`define CAP_SPACE_DEFINES_SVH

`define CFG_ADDR_W 24
`define CAP_SPACE_HI 24'h00003C
`define CSR_SPACE_LO 24'h000040
`define CSR_SPACE_HI 24'h0000FC
`define EXT_SPACE_LO 24'h000100
`define EXT_SPACE_HI 24'h00FFFC
`define IMP_SPACE_LO 24'h010000
`define IMP_SPACE_HI 24'hFFFFFC

`define OFS_DEV_IDENT 6'h00
`define OFS_DEV_INFO 6'h04
`define OFS_ASM_IDENT 6'h08
`define OFS_ASM_INFO 6'h0C
`define OFS_PE_FEAT 6'h10
`define OFS_SW_PORT 6'h14
`define OFS_SRC_OPS 6'h18
`define OFS_DST_OPS 6'h1C
`define OFS_RSVD_LO 6'h20
`define CAP_OFS_MSB 5
`define CAP_OFS_LSB 0
`define WORD_ALIGN_MSB 1
`define WORD_ALIGN_LSB 0

`define ADR_DEV_IDENT 24'h000000
`define ADR_DEV_INFO 24'h000004
`define ADR_ASM_IDENT 24'h000008
`define ADR_ASM_INFO 24'h00000C
`define ADR_PE_FEAT 24'h000010
`define ADR_SW_PORT 24'h000014
`define ADR_SRC_OPS 24'h000018
`define ADR_DST_OPS 24'h00001C
`define ADR_RSVD_LO 24'h000020

`define INFO_RSVD_HI_MSB 31
`define INFO_RSVD_HI_LSB 20
`define INFO_LABEL_MSB 19
`define INFO_LABEL_LSB 16
`define INFO_RSVD_MID_MSB 15
`define INFO_RSVD_MID_LSB 12
`define INFO_MAJOR_MSB 11
`define INFO_MAJOR_LSB 8
`define INFO_MINOR_MSB 7
`define INFO_MINOR_LSB 4
`define INFO_PATCH_MSB 3
`define INFO_PATCH_LSB 0
`define HALF_HI_MSB 31
`define HALF_HI_LSB 16
`define HALF_LO_MSB 15
`define HALF_LO_LSB 0

`define REV_LABEL 4'h2
`define REV_MAJOR 4'h3
`define REV_MINOR 4'h0
`define REV_PATCH 4'h0
`define EXT_PTR_DEFAULT 16'h0100
`define ZERO_WORD 32'h00000000

`endif

// ---- cap_space_pkg.sv ----
// Purpose: Types shared by the capability register bank.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only.
package cap_space_pkg;

	typedef enum logic [3:0] {
		UNIT_LOG_CAP = 4'h1,
		UNIT_LOG_CSR = 4'h2,
		UNIT_PHY = 4'h4,
		UNIT_BUF = 4'h8
	} cfg_unit_t;

	typedef struct packed {
		logic [3:0] zero_hi_a;
		logic [7:0] zero_hi_b;
		logic [3:0] rev_label;
		logic [3:0] zero_mid;
		logic [3:0] rev_major;
		logic [3:0] rev_minor;
		logic [3:0] rev_patch;
	} dev_info_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [23:0] addr;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] rdata;
	} cfg_rsp_t;

endpackage

// ---- capability_register_space.sv ----
// Purpose: Read-only capability register bank and configuration-space decode.
// Assumes: One request per cycle, answered one cycle later; the requester merges
//   the local maintenance port and link-partner traffic ahead of this block.
// Notes: Reads outside the capability space answer zero here, except lite-option remote reads from 0x010000 up;
//   their unit select tells the caller which sub-unit owns them.
// Contract
// - Decode offsets into capability, command/status, physical and buffer/logical spaces.
// - All capability registers are read-only and live in the logical unit.
// - Eight 32-bit registers at 0x00 to 0x1C; 0x20 to 0x3C reserved.
// - Features register carries physical-layer bits yet sits in the logical unit.
// - Maintenance request information register exists only with the lite port option.
// - That register is reachable only via remote (link-partner) requests, not the local maintenance port.
// - Device identity is fixed: device code high, vendor code low.
// - Device information bits 19:16 read revision label 2.
// - Major release 3 in bits 11:8, minor 0 in bits 7:4.
// - Patch level bits 3:0 read 0.
// - Reserved device information bits 31:20 and 15:12 read zero.
// - Assembly information low half returns extended-features pointer, default 0x0100.
`include "cap_space_defines.svh"

module capability_register_space #(
	parameter logic [15:0] DEVICE_CODE = 16'h00A5, // Arbitrary value
	parameter logic [15:0] VENDOR_CODE = 16'h005A, // Arbitrary value
	parameter logic [31:0] ASM_IDENT = 32'h00000000,
	parameter logic [15:0] ASM_REVISION = 16'h0000,
	parameter logic [15:0] EXT_PTR = `EXT_PTR_DEFAULT,
	parameter logic [31:0] PE_FEATURES = 32'h00000009,
	parameter logic [31:0] SRC_OPS = 32'h00000000,
	parameter logic [31:0] DST_OPS = 32'h00000000,
	parameter bit MAINT_LITE_EN = 1'b0,
	parameter int ADDR_W = `CFG_ADDR_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire cap_space_pkg::cfg_req_t maint_req,
	input wire logic maint_req_remote,
	input wire logic [31:0] maint_info_value,
	output cap_space_pkg::cfg_rsp_t maint_rsp,
	output cap_space_pkg::cfg_unit_t unit_sel,
	output logic maint_info_present
);

	// Decode and offsets are laid out for a 24-bit byte offset only
	if (ADDR_W != `CFG_ADDR_W) begin : g_addr_w_check
		$error("capability_register_space: ADDR_W must be 24");
	end

	cap_space_pkg::cfg_rsp_t rsp_ff;
	cap_space_pkg::cfg_rsp_t nxt_rsp;
	cap_space_pkg::cfg_unit_t unit_ff;
	cap_space_pkg::cfg_unit_t nxt_unit;
	cap_space_pkg::dev_info_t info_word;
	logic [`CAP_OFS_MSB:`CAP_OFS_LSB] cap_ofs;

	assign cap_ofs = maint_req.addr[`CAP_OFS_MSB:`CAP_OFS_LSB];

	always_comb begin
		info_word = '0;
		info_word.rev_label = `REV_LABEL;
		info_word.rev_major = `REV_MAJOR;
		info_word.rev_minor = `REV_MINOR;
		info_word.rev_patch = `REV_PATCH;
	end

	// Sub-unit decode of the byte offset
	always_comb begin
		if (maint_req.addr <= `CAP_SPACE_HI) begin
			nxt_unit = cap_space_pkg::UNIT_LOG_CAP;
		end else if (maint_req.addr <= `CSR_SPACE_HI) begin
			nxt_unit = cap_space_pkg::UNIT_LOG_CSR;
		end else if (maint_req.addr <= `EXT_SPACE_HI) begin
			nxt_unit = cap_space_pkg::UNIT_PHY;
		end else begin
			nxt_unit = cap_space_pkg::UNIT_BUF;
		end
	end

	// Read mux; writes only get an answer, no state changes
	always_comb begin
		nxt_rsp.valid = maint_req.valid;
		nxt_rsp.rdata = `ZERO_WORD;
		if (maint_req.valid && !maint_req.write && nxt_unit == cap_space_pkg::UNIT_LOG_CAP) begin
			unique case (cap_ofs)
				`OFS_DEV_IDENT: nxt_rsp.rdata = {DEVICE_CODE, VENDOR_CODE};
				`OFS_DEV_INFO: nxt_rsp.rdata = info_word;
				`OFS_ASM_IDENT: nxt_rsp.rdata = ASM_IDENT;
				`OFS_ASM_INFO: nxt_rsp.rdata = {ASM_REVISION, EXT_PTR};
				`OFS_PE_FEAT: nxt_rsp.rdata = PE_FEATURES;
				`OFS_SW_PORT: nxt_rsp.rdata = `ZERO_WORD;
				`OFS_SRC_OPS: nxt_rsp.rdata = SRC_OPS;
				`OFS_DST_OPS: nxt_rsp.rdata = DST_OPS;
				default: nxt_rsp.rdata = `ZERO_WORD;
			endcase
		end else if (maint_req.valid && !maint_req.write && nxt_unit == cap_space_pkg::UNIT_BUF
				&& MAINT_LITE_EN && maint_req_remote) begin
			nxt_rsp.rdata = maint_info_value;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rsp_ff <= '0;
			unit_ff <= cap_space_pkg::UNIT_LOG_CAP;
		end else begin
			rsp_ff <= nxt_rsp;
			unit_ff <= nxt_unit;
		end
	end

	assign maint_rsp = rsp_ff;
	assign unit_sel = unit_ff;
	assign maint_info_present = MAINT_LITE_EN;

	// Answer timing and write handling
	a_rsp_follows_req: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid
		|=> maint_rsp.valid)
		else $error("no answer");
	a_no_stray_rsp: assert property (@(posedge clk_sys) disable iff (rst)
		!maint_req.valid
		|=> !maint_rsp.valid && maint_rsp.rdata == `ZERO_WORD)
		else $error("stray answer");
	a_write_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.write
		|=> maint_rsp.valid && maint_rsp.rdata == `ZERO_WORD)
		else $error("write returned data");

	// Fixed capability register words, reserved and unaligned offsets
	a_dev_ident_fixed: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_DEV_IDENT
		|=> maint_rsp.rdata == {DEVICE_CODE, VENDOR_CODE})
		else $error("ident");
	a_rev_label_two: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_DEV_INFO
		|=> maint_rsp.rdata[`INFO_LABEL_MSB:`INFO_LABEL_LSB] == `REV_LABEL)
		else $error("label");
	a_major_minor_rev: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_DEV_INFO
		|=> maint_rsp.rdata[`INFO_MAJOR_MSB:`INFO_MAJOR_LSB] == `REV_MAJOR
			&& maint_rsp.rdata[`INFO_MINOR_MSB:`INFO_MINOR_LSB] == `REV_MINOR)
		else $error("release");
	a_patch_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_DEV_INFO
		|=> maint_rsp.rdata[`INFO_PATCH_MSB:`INFO_PATCH_LSB] == `REV_PATCH)
		else $error("patch");
	a_info_rsvd_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.addr == `ADR_DEV_INFO
		|=> maint_rsp.rdata[`INFO_RSVD_HI_MSB:`INFO_RSVD_HI_LSB] == '0
			&& maint_rsp.rdata[`INFO_RSVD_MID_MSB:`INFO_RSVD_MID_LSB] == '0)
		else $error("reserved");
	a_ext_ptr_value: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_ASM_INFO
		|=> maint_rsp.rdata[`HALF_LO_MSB:`HALF_LO_LSB] == EXT_PTR)
		else $error("pointer");
	a_asm_rev_value: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_ASM_INFO
		|=> maint_rsp.rdata[`HALF_HI_MSB:`HALF_HI_LSB] == ASM_REVISION)
		else $error("assembly revision");
	a_asm_ident_value: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_ASM_IDENT
		|=> maint_rsp.rdata == ASM_IDENT)
		else $error("assembly identity");
	a_pe_feat_value: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_PE_FEAT
		|=> maint_rsp.rdata == PE_FEATURES)
		else $error("features");
	a_sw_port_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.addr == `ADR_SW_PORT
		|=> maint_rsp.rdata == `ZERO_WORD)
		else $error("switch port");
	a_src_ops_value: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_SRC_OPS
		|=> maint_rsp.rdata == SRC_OPS)
		else $error("source operations");
	a_dst_ops_value: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && !maint_req.write && maint_req.addr == `ADR_DST_OPS
		|=> maint_rsp.rdata == DST_OPS)
		else $error("destination operations");
	a_rsvd_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.addr >= `ADR_RSVD_LO && maint_req.addr <= `CAP_SPACE_HI
		|=> maint_rsp.rdata == `ZERO_WORD)
		else $error("reserved offset");
	a_unaligned_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.addr <= `CAP_SPACE_HI
			&& maint_req.addr[`WORD_ALIGN_MSB:`WORD_ALIGN_LSB] != '0
		|=> maint_rsp.rdata == `ZERO_WORD)
		else $error("unaligned read");

	// Sub-unit decode
	a_cap_decode: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.addr <= `CAP_SPACE_HI
		|=> unit_sel == cap_space_pkg::UNIT_LOG_CAP)
		else $error("capability decode");
	a_csr_decode: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.addr >= `CSR_SPACE_LO && maint_req.addr <= `CSR_SPACE_HI
		|=> unit_sel == cap_space_pkg::UNIT_LOG_CSR)
		else $error("csr decode");
	a_phy_decode: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.addr >= `EXT_SPACE_LO && maint_req.addr <= `EXT_SPACE_HI
		|=> unit_sel == cap_space_pkg::UNIT_PHY)
		else $error("phy decode");
	a_unit_decode: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.addr >= `IMP_SPACE_LO
		|=> unit_sel == cap_space_pkg::UNIT_BUF)
		else $error("decode");
	a_unit_onehot: assert property (@(posedge clk_sys) disable iff (rst)
		$onehot(unit_sel))
		else $error("unit select not one-hot");
	a_csr_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.addr >= `CSR_SPACE_LO && maint_req.addr <= `CSR_SPACE_HI
		|=> maint_rsp.rdata == `ZERO_WORD)
		else $error("csr read data");
	a_phy_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.addr >= `EXT_SPACE_LO && maint_req.addr <= `EXT_SPACE_HI
		|=> maint_rsp.rdata == `ZERO_WORD)
		else $error("phy read data");

	// Maintenance request information word
	a_info_local_hidden: assert property (@(posedge clk_sys) disable iff (rst)
		maint_req.valid && maint_req.addr >= `IMP_SPACE_LO && !maint_req_remote
		|=> maint_rsp.rdata == `ZERO_WORD)
		else $error("info exposed");
	a_info_absent: assert property (@(posedge clk_sys) disable iff (rst)
		!MAINT_LITE_EN && maint_req.valid && maint_req.addr >= `IMP_SPACE_LO
		|=> maint_rsp.rdata == `ZERO_WORD)
		else $error("info present without option");
	a_info_remote_read: assert property (@(posedge clk_sys) disable iff (rst)
		MAINT_LITE_EN && maint_req.valid && !maint_req.write && maint_req_remote
			&& maint_req.addr >= `IMP_SPACE_LO
		|=> maint_rsp.rdata == $past(maint_info_value))
		else $error("info not returned");

endmodule // capability_register_space

// ---- maint_requester.sv ----
// Purpose: Maintenance requester standing in for the local port or link partner.
// Assumes: Each task is entered just after a falling clk_sys edge.
// Notes: Released address, data and remote fields are inverted so a stale request never looks live.
module maint_requester (
	input wire logic clk_sys,
	input wire cap_space_pkg::cfg_rsp_t maint_rsp,
	output cap_space_pkg::cfg_req_t maint_req,
	output logic maint_req_remote
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		maint_req = '0;
		maint_req_remote = 1'h0;
	end
	// Holds the request one cycle, returns what stands after the taking edge
	task automatic xfer(input logic w, input logic [23:0] a, input logic [31:0] d,
		input logic r, output cap_space_pkg::cfg_rsp_t rsp);
		maint_req = {1'h1, w, a, d};
		maint_req_remote = r;
		@(negedge clk_sys);
		rsp = maint_rsp;
	endtask
	task automatic idle();
		maint_req = {1'h0, maint_req.write, ~maint_req.addr, ~maint_req.wdata};
		maint_req_remote = ~maint_req_remote;
		@(negedge clk_sys);
	endtask
endmodule // maint_requester

// ---- capability_register_space_bench.sv ----
// Purpose: Self-checking bench for the capability register bank.
// Assumes: Requests go back to back through the requester model.
// Notes: Identity codes below are arbitrary values.
module capability_register_space_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] DEV = 16'h1234; // Arbitrary value
	localparam logic [15:0] VEN = 16'h0042; // Arbitrary value
	localparam logic [31:0] CAP [8] = '{{DEV, VEN}, 32'h00020300, 32'hA5A50001,
		32'h00070100, 32'h00000039, 32'h0, 32'h0000FFF8, 32'h0000C000};
	logic clk_sys, rst, maint_req_remote, maint_info_present;
	logic [31:0] maint_info_value;
	cap_space_pkg::cfg_req_t maint_req;
	cap_space_pkg::cfg_rsp_t maint_rsp, rsp;
	cap_space_pkg::cfg_unit_t unit_sel;
	cap_space_pkg::cfg_rsp_t maint_rsp_bare;
	cap_space_pkg::cfg_unit_t unit_sel_bare;
	logic present_bare;
	int err_count = 0;
	int comparisons = 0;
	capability_register_space #(.DEVICE_CODE(DEV), .VENDOR_CODE(VEN), .ASM_IDENT(CAP[2]),
		.ASM_REVISION(16'h0007), .PE_FEATURES(CAP[4]), .SRC_OPS(CAP[6]),
		.DST_OPS(CAP[7]), .MAINT_LITE_EN(1'h1)) i_dut (.clk_sys(clk_sys), .rst(rst),
		.maint_req(maint_req), .maint_req_remote(maint_req_remote),
		.maint_info_value(maint_info_value), .maint_rsp(maint_rsp), .unit_sel(unit_sel),
		.maint_info_present(maint_info_present));
	// Second bank with the lite port option off, fed the same requests
	capability_register_space i_dut_bare (.clk_sys(clk_sys), .rst(rst), .maint_req(maint_req),
		.maint_req_remote(maint_req_remote), .maint_info_value(maint_info_value),
		.maint_rsp(maint_rsp_bare), .unit_sel(unit_sel_bare), .maint_info_present(present_bare));
	maint_requester i_req (.clk_sys(clk_sys), .maint_rsp(maint_rsp), .maint_req(maint_req),
		.maint_req_remote(maint_req_remote));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [23:0] a, input logic r,
		input logic [31:0] exp, input logic [3:0] u);
		i_req.xfer(w, a, 32'hFFFFFFFF, r, rsp);
		check({31'h0, rsp.valid}, 32'h1);
		check(rsp.rdata, exp);
		check({28'h0, unit_sel}, {28'h0, u});
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#50000;
		err_count++;
		end_of_test();
	end
	initial begin
		rst = 1'h1;
		maint_info_value = 32'hC0DE0F01;
		repeat (16) @(negedge clk_sys);
		check({maint_rsp.valid, unit_sel}, 5'h01);
		rst = 1'h0;
		check({31'h0, maint_info_present}, 32'h1);
		for (int i = 0; i < 16; i++) begin
			acc(1'h0, 24'(i * 4), 1'h0, (i < 8) ? CAP[i] : 32'h0, 4'h1);
		end
		acc(1'h1, 24'h000004, 1'h0, 32'h0, 4'h1);
		acc(1'h0, 24'h000004, 1'h0, CAP[1], 4'h1);
		acc(1'h0, 24'h000006, 1'h0, 32'h0, 4'h1);
		rst = 1'h1;
		i_req.idle();
		check({maint_rsp.valid, unit_sel}, 5'h01);
		check(maint_rsp.rdata, 32'h0);
		rst = 1'h0;
		acc(1'h0, 24'h000000, 1'h0, CAP[0], 4'h1);
		i_req.idle();
		check({31'h0, maint_rsp.valid}, 32'h0);
		check(maint_rsp.rdata, 32'h0);
		acc(1'h0, 24'h000040, 1'h0, 32'h0, 4'h2);
		acc(1'h0, 24'h0000FC, 1'h0, 32'h0, 4'h2);
		acc(1'h0, 24'h000100, 1'h0, 32'h0, 4'h4);
		acc(1'h0, 24'h00FFFC, 1'h0, 32'h0, 4'h4);
		acc(1'h0, 24'h010000, 1'h0, 32'h0, 4'h8);
		acc(1'h0, 24'hFFFFFC, 1'h1, 32'hC0DE0F01, 4'h8);
		check(maint_rsp_bare.rdata, 32'h0);
		check({28'h0, unit_sel_bare}, 32'h8);
		check({31'h0, present_bare}, 32'h0);
		i_req.idle();
		end_of_test();
	end
endmodule // capability_register_space_bench
